// File: bench/evctl_sw_model.sv
`timescale 1ns/1ps
module evctl_sw_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] ext_switch,
  input wire logic [15:0] mppt_target,
  input wire logic [15:0] mppt_vbat,
  output logic [11:0] sw_state,
  output logic [15:0] trk_target,
  output logic [15:0] trk_vbat,
  output int flips
);
  // Switch devices latch commands; tracker latches its voltages
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_state <= 12'h000;
      trk_target <= 16'h0000;
      trk_vbat <= 16'h0000;
      flips <= 0;
    end else begin
      sw_state <= ext_switch;
      trk_target <= mppt_target;
      trk_vbat <= mppt_vbat;
      if (ext_switch[0] !== sw_state[0]) begin
        flips <= flips + 1;
      end
    end
  end
endmodule

// File: bench/evctl_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); \
  end \
end
module evctl_top_test;
  import evctl_pkg::*;
  localparam logic [15:0] VB [6] = '{16'h079E, 16'h0802, 16'h0835,
    16'h0802, 16'h079E, 16'h076B};
  localparam logic [5:0] RX = 6'b100011;
  localparam logic [11:0] INV = 12'h5A3;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic sense_in = 1'b0, in_float = 1'b0, is_night = 1'b0;
  logic lvd_on = 1'b0, alarm_on = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, event_on, ind;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [11:0] ext_switch, sw_state, exp_sw;
  logic [15:0] mppt_target, mppt_vbat, trk_target, trk_vbat;
  logic [2:0] digits;
  logic [1:0] rs, br;
  logic [3:0] srcv;
  logic st, prev;
  int flips, f0, rises, hi, i, q;
  int num_errors = 0;
  int tests_run = 0;

  evctl_top #(.TICK_CYCLES(4), .TICKS_PER_MIN(3)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sense_in(sense_in), .in_float(in_float),
    .is_night(is_night), .lvd_on(lvd_on), .alarm_on(alarm_on),
    .ext_switch(ext_switch), .mppt_target(mppt_target),
    .mppt_vbat(mppt_vbat), .event_on(event_on),
    .event_inactive_indicator(ind), .status_digits(digits)
  );

  evctl_sw_model model_u (
    .aclk(aclk), .aresetn(aresetn), .ext_switch(ext_switch),
    .mppt_target(mppt_target), .mppt_vbat(mppt_vbat),
    .sw_state(sw_state), .trk_target(trk_target), .trk_vbat(trk_vbat),
    .flips(flips)
  );

  always #10 aclk = ~aclk;

  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic settle;
    repeat (40) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    rst();
    axr(8'h20);
    `CHK("unmapped_resp", 2'b10, rs)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    axw(8'h20, 32'hFFFF_FFFF);
    `CHK("wr_unmapped", 2'b10, br)
    for (q = 1; q < 4; q++) begin
      for (i = 0; i < 4; i++) begin
        axw(OFS_CFG, {20'h00000, q[3:0], 8'h00});
        @(posedge aclk);
        in_float <= i[0];
        is_night <= i[1];
        settle();
        st = (q == 1) ? i[0] : (q == 2) ? i[1] : !i[1];
        `CHK("digits", {!st, st, 1'b1}, digits)
        `CHK("event", st, event_on)
        `CHK("indicator", !st, ind)
      end
    end
    axr(OFS_STAT);
    `CHK("stat", {27'h0, st, 1'b0, !st, st, 1'b1}, rd)
    rst();
    axw(OFS_TIME, 32'h0000_0000);
    axw(OFS_TOD, 32'h0000_0001);
    axw(OFS_CFG, 32'h0000_0070);
    `CHK("wr_okay", 2'b00, br)
    settle();
    `CHK("stop_blocks", 1'b0, event_on)
    `CHK("stop_digits", 3'b111, digits)
    @(posedge aclk);
    sense_in <= 1'b1;
    settle();
    `CHK("closed_on", 4'b1011, {event_on, digits})
    @(posedge aclk);
    sense_in <= 1'b0;
    settle();
    `CHK("open_off", 1'b0, event_on)
    rst();
    axw(OFS_TIME, 32'h0000_0005);
    axw(OFS_TOD, 32'h0000_0003);
    axw(OFS_CFG, 32'h0000_0070);
    settle();
    axw(OFS_CFG, 32'h0000_0006);
    @(posedge aclk);
    sense_in <= 1'b1;
    settle();
    `CHK("pb_early", 2'b00, {event_on, digits[2]})
    axw(OFS_TOD, 32'h0000_0006);
    settle();
    `CHK("pb_late", 1'b1, event_on)
    rst();
    axw(OFS_TIME, 32'h000E_0000);
    axw(OFS_TOD, 32'h0000_000E);
    axw(OFS_CFG, 32'h0000_7000);
    settle();
    `CHK("thr_equal", 4'b0110, {event_on, digits})
    axw(OFS_TOD, 32'h0000_000F);
    settle();
    `CHK("thr_after", 4'b1011, {event_on, digits})
    rst();
    axw(OFS_RATE, 32'h0001_0002);
    axw(OFS_CFG, 32'h0000_00EE);
    rises = 0;
    hi = 0;
    prev = 1'b0;
    repeat (240) begin
      @(negedge aclk);
      if (event_on && !prev) rises++;
      prev = event_on;
      if (event_on) hi++;
    end
    `CHK("rate_starts", 1'b1, rises >= 8 && rises <= 11)
    `CHK("run_share", 1'b1, hi >= 72 && hi <= 168)
    rst();
    axw(OFS_VOLT, 32'h07D0_03E8);
    axw(OFS_SW, 32'h00E4_E4E4);
    axw(OFS_OUT, {20'h00000, INV});
    for (i = 0; i < 4; i++) begin
      @(posedge aclk);
      lvd_on <= i[0];
      alarm_on <= i[1];
      settle();
      srcv = {1'b1, i[1], i[0], 1'b1};
      for (q = 0; q < 12; q++) exp_sw[q] = srcv[q % 4] ^ INV[q];
      `CHK("switches", exp_sw, sw_state)
    end
    `CHK("trk_target", 16'h07D0, trk_target)
    `CHK("trk_vbat", 16'h03E8, trk_vbat)
    f0 = flips;
    for (i = 0; i < 6; i++) begin
      axw(OFS_VOLT, {16'h07D0, VB[i]});
      settle();
      `CHK("reg_switch", RX[i] ^ INV[0], sw_state[0])
    end
    `CHK("reg_flips", 2, flips - f0)
    summarize();
  end
endmodule

// File: logic/evctl_pkg.sv
package evctl_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int NSW = 12;
  // Register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_TOD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_SW = 8'h14;
  localparam logic [7:0] OFS_VOLT = 8'h18;
  localparam logic [7:0] OFS_OUT = 8'h1C;
  // Field positions in the configuration word
  localparam int F_BEGIN = 0;
  localparam int F_STOP = 4;
  localparam int F_STQ = 8;
  localparam int F_THQ = 12;
  // Condition codes
  localparam logic [3:0] C_ALWAYS = 4'h0;
  localparam logic [3:0] C_PB_ON = 4'h6;
  localparam logic [3:0] C_PB_OFF = 4'h7;
  localparam logic [3:0] C_RATE = 4'hE;
  localparam logic [3:0] Q_FLOAT = 4'h1;
  localparam logic [3:0] Q_NIGHT = 4'h2;
  localparam logic [3:0] Q_DAY = 4'h3;
  localparam logic [3:0] T_TIME = 4'h7;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Evaluation tick and minute timing
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int MIN_TICKS = 60000;
  // Hysteresis band for the regulator switch, in millivolts
  localparam logic [15:0] HYST_MV = 16'h0064;
  typedef enum logic [1:0] {
    SRC_REG, SRC_LVD, SRC_ALARM, SRC_EVENT
  } evctl_src_e;
endpackage

// File: logic/evctl_sw_if.sv
`timescale 1ns/1ps
interface evctl_sw_if;
  logic [23:0] src_sel;
  logic [11:0] invert;
  logic reg_on;
  logic lvd_on;
  logic alarm_on;
  logic event_on;
  logic [11:0] sw_cmd;
  modport ctl (output src_sel, invert, reg_on, lvd_on, alarm_on, event_on,
    input sw_cmd);
  modport mux (input src_sel, invert, reg_on, lvd_on, alarm_on, event_on,
    output sw_cmd);
endinterface

// File: logic/evctl_sw_mux.sv
`timescale 1ns/1ps
module evctl_sw_mux
  import evctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  evctl_sw_if.mux sw
);
  logic [11:0] sw_r;
  wire [11:0] sel_w;
  genvar i;
  generate
    for (i = 0; i < NSW; i++) begin : g_sw
      wire [1:0] s = sw.src_sel[2*i +: 2];
      // Four selectable sources, optional inversion
      assign sel_w[i] = ((s == 2'(SRC_REG)) ? sw.reg_on :
        (s == 2'(SRC_LVD)) ? sw.lvd_on :
        (s == 2'(SRC_ALARM)) ? sw.alarm_on : sw.event_on)
        ^ sw.invert[i];
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r <= '0;
    end else begin
      sw_r <= sel_w;
    end
  end
  assign sw.sw_cmd = sw_r;
  muxed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> sw.sw_cmd[0] == $past(sel_w[0])) else $error("first switch");
endmodule

// File: logic/evctl_top.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// - First digit shows begin condition when off, stop condition when on.
// - Second digit shows the state qualifier.
// - Third digit shows threshold qualifier; unused qualifier reads 1.
// - Event active only while both qualifiers hold and no stop; begin needed only to start.
// - Begin code 0 is always true; stop code 0 never true.
// - State qualifier 1 float, 2 night, 3 day.
// - Begin code 6: push-button asserted and time of day above setting.
// - Stop code 7: sense input deasserts.
// - Begin code 14 pulses once every rate interval in minutes.
// - Stop code 14 fires after run time minutes since each start.
// - Threshold code 7 active while time of day exceeds setting.
// - Twelve external switches, numbered 1 to 9 then A, B, C.
// - Each switch driven by regulator, disconnect, alarm or event.
// - Each switch may take the inverse of its source.
// - Tracker gets target and battery voltage, regulator only.
// - Regulator switch toggles with hysteresis to limit transitions.
// - Turns on when all three active; off on stop or qualifier loss.
// - Stop active at start blocks the start.
module evctl_top
  import evctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int TICKS_PER_MIN = MIN_TICKS
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sense_in,
  input wire logic in_float,
  input wire logic is_night,
  input wire logic lvd_on,
  input wire logic alarm_on,
  output logic [11:0] ext_switch,
  output logic [15:0] mppt_target,
  output logic [15:0] mppt_vbat,
  output logic event_on,
  output logic event_inactive_indicator,
  output logic [2:0] status_digits
);
  if (TICK_CYCLES < 1 || TICKS_PER_MIN < 1) begin : g_bad_cnt
    $error("evctl_top: counts must be at least one");
  end
  evctl_sw_if swb();
  evctl_sw_mux u_mux (.aclk(aclk), .aresetn(aresetn), .sw(swb));

  // Registers
  logic [31:0] cfg_r, time_r, rate_r, tod_r, sw_r, volt_r;
  logic [11:0] inv_r;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_OUT);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      o[8*b +: 8] = st[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
    merge = o;
  endfunction

  wire wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= RST_ZERO;
      bresp_r <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awa_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= merge(RST_ZERO, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awa_r) ? 2'h0 : 2'h2;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic [3:0] wst_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wst_r <= s_axi_wstrb;
    end
  end

  wire [31:0] inv_mrg = merge({20'h0, inv_r}, wd_r, wst_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= RST_ZERO;
      time_r <= RST_ZERO;
      rate_r <= RST_ZERO;
      tod_r <= RST_ZERO;
      sw_r <= RST_ZERO;
      volt_r <= RST_ZERO;
      inv_r <= 12'h000;
    end else if (wr_go) begin
      if (awa_r == OFS_CFG) begin
        cfg_r <= merge(cfg_r, wd_r, wst_r);
      end else if (awa_r == OFS_TIME) begin
        time_r <= merge(time_r, wd_r, wst_r);
      end else if (awa_r == OFS_RATE) begin
        rate_r <= merge(rate_r, wd_r, wst_r);
      end else if (awa_r == OFS_TOD) begin
        tod_r <= merge(tod_r, wd_r, wst_r);
      end else if (awa_r == OFS_SW) begin
        sw_r <= merge(sw_r, wd_r, wst_r);
      end else if (awa_r == OFS_VOLT) begin
        volt_r <= merge(volt_r, wd_r, wst_r);
      end else if (awa_r == OFS_OUT) begin
        inv_r <= inv_mrg[11:0];
      end
    end
  end

  // Input synchroniser
  logic sn_m_r, sn_r, fl_m_r, fl_r, nt_m_r, nt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sn_m_r, sn_r, fl_m_r, fl_r, nt_m_r, nt_r} <= 6'h00;
    end else begin
      {sn_m_r, fl_m_r, nt_m_r} <= {sense_in, in_float, is_night};
      {sn_r, fl_r, nt_r} <= {sn_m_r, fl_m_r, nt_m_r};
    end
  end

  // Evaluation tick and minute count
  logic [31:0] tick_cnt_r, min_cnt_r, rate_cnt_r, run_cnt_r;
  wire tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  wire minute = tick && (min_cnt_r == 32'(TICKS_PER_MIN - 1));

  wire [3:0] bsel = cfg_r[F_BEGIN +: 4];
  wire [3:0] ssel = cfg_r[F_STOP +: 4];
  wire [3:0] qsel = cfg_r[F_STQ +: 4];
  wire [3:0] tsel = cfg_r[F_THQ +: 4];
  wire [15:0] tod = tod_r[15:0];
  wire time_gt_begin = tod > time_r[15:0];
  wire time_gt_thr = tod > time_r[31:16];
  logic ev_r;
  logic [2:0] dig_r;

  wire rate_hit = minute && (rate_cnt_r + 32'h1 >= {16'h0, rate_r[15:0]});
  // Gated by the event so a spent run never blocks the next start
  wire run_done = ev_r && (run_cnt_r >= {16'h0, rate_r[31:16]});
  wire begin_c = (bsel == C_ALWAYS) ? 1'b1 :
    (bsel == C_PB_ON) ? (sn_r && time_gt_begin) :
    (bsel == C_RATE) ? rate_hit : 1'b0;
  wire stop_c = (ssel == C_ALWAYS) ? 1'b0 :
    (ssel == C_PB_OFF) ? !sn_r :
    (ssel == C_RATE) ? run_done : 1'b0;
  wire stq_c = (qsel == C_ALWAYS) ? 1'b1 :
    (qsel == Q_FLOAT) ? fl_r :
    (qsel == Q_NIGHT) ? nt_r :
    (qsel == Q_DAY) ? !nt_r : 1'b0;
  wire thq_c = (tsel == C_ALWAYS) ? 1'b1 :
    (tsel == T_TIME) ? time_gt_thr : 1'b0;
  // Start needs all three and no stop; stop or qualifier loss ends it
  wire ev_nxt = ev_r ? (!stop_c && stq_c && thq_c) :
    (begin_c && !stop_c && stq_c && thq_c);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= RST_ZERO;
      min_cnt_r <= RST_ZERO;
      rate_cnt_r <= RST_ZERO;
      run_cnt_r <= RST_ZERO;
      ev_r <= 1'b0;
      dig_r <= 3'h0;
    end else begin
      tick_cnt_r <= tick ? RST_ZERO : tick_cnt_r + 32'h1;
      if (tick) begin
        min_cnt_r <= minute ? RST_ZERO : min_cnt_r + 32'h1;
        ev_r <= ev_nxt;
        dig_r <= {ev_nxt ? stop_c : begin_c, stq_c, thq_c};
        if (minute) begin
          rate_cnt_r <= rate_hit ? RST_ZERO : rate_cnt_r + 32'h1;
        end
        if (ev_nxt && !ev_r) begin
          run_cnt_r <= RST_ZERO;
        end else if (minute && ev_r) begin
          run_cnt_r <= run_cnt_r + 32'h1;
        end
      end
    end
  end

  // Regulator switch with hysteresis
  logic reg_r;
  wire [15:0] vbat = volt_r[15:0];
  wire [15:0] vtgt = volt_r[31:16];
  // Widened so the band cannot wrap near full scale
  wire [16:0] vbat_up = {1'b0, vbat} + {1'b0, HYST_MV};
  wire [16:0] vtgt_up = {1'b0, vtgt} + {1'b0, HYST_MV};
  wire reg_up = vbat_up < {1'b0, vtgt};
  wire reg_dn = {1'b0, vbat} > vtgt_up;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_r <= 1'b0;
      mppt_target <= 16'h0000;
      mppt_vbat <= 16'h0000;
    end else begin
      if (reg_up) begin
        reg_r <= 1'b1;
      end else if (reg_dn) begin
        reg_r <= 1'b0;
      end
      mppt_target <= vtgt;
      mppt_vbat <= vbat;
    end
  end

  assign swb.src_sel = sw_r[23:0];
  assign swb.invert = inv_r;
  assign swb.reg_on = reg_r;
  assign swb.lvd_on = lvd_on;
  assign swb.alarm_on = alarm_on;
  assign swb.event_on = ev_r;
  assign ext_switch = swb.sw_cmd;
  assign event_on = ev_r;
  assign event_inactive_indicator = !ev_r;
  assign status_digits = dig_r;

  wire [31:0] stat_w = {27'h0, ev_r, 1'b0, dig_r};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= RST_ZERO;
      rresp_r <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      rdata_r <= (s_axi_araddr == OFS_CFG) ? cfg_r :
        (s_axi_araddr == OFS_TIME) ? time_r :
        (s_axi_araddr == OFS_RATE) ? rate_r :
        (s_axi_araddr == OFS_TOD) ? tod_r :
        (s_axi_araddr == OFS_STAT) ? stat_w :
        (s_axi_araddr == OFS_SW) ? sw_r :
        (s_axi_araddr == OFS_VOLT) ? volt_r :
        (s_axi_araddr == OFS_OUT) ? {20'h0, inv_r} : RST_ZERO;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Event checks
  ev_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && ev_r && stop_c |=> !ev_r) else $error("stop ignored");
  ev_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !ev_r && stop_c |=> !ev_r) else $error("start past stop");
  ev_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && ev_nxt |-> stq_c && thq_c) else $error("event alone");
  ev_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !ev_r && begin_c && !stop_c && stq_c && thq_c |=> ev_r)
    else $error("start ignored");
  ev_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(ev_r)) else $error("event off tick");
  dig_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(dig_r)) else $error("digits off tick");
  dig_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> dig_r[2] == (ev_r ? $past(stop_c) : $past(begin_c)))
    else $error("digit one");
  dig_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> dig_r[1] == $past(stq_c)) else $error("digit two");
  dig_three_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && tsel == C_ALWAYS |=> dig_r[0]) else $error("digit three");
  // Condition decode checks
  begin_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bsel == C_ALWAYS |-> begin_c) else $error("begin code zero");
  stop_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ssel == C_ALWAYS |-> !stop_c) else $error("stop code zero");
  stq_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    qsel == C_ALWAYS |-> stq_c) else $error("state code zero");
  stq_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    qsel == Q_FLOAT |-> stq_c == fl_r) else $error("float qualifier");
  stq_night_a: assert property (@(posedge aclk) disable iff (!aresetn)
    qsel == Q_NIGHT |-> stq_c == nt_r) else $error("night qualifier");
  stq_day_a: assert property (@(posedge aclk) disable iff (!aresetn)
    qsel == Q_DAY |-> stq_c == !nt_r) else $error("day qualifier");
  pb_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bsel == C_PB_ON && !time_gt_begin |-> !begin_c)
    else $error("button too early");
  pb_begin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bsel == C_PB_ON && sn_r && time_gt_begin |-> begin_c)
    else $error("button start");
  pb_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ssel == C_PB_OFF |-> stop_c == !sn_r) else $error("contact stop");
  rate_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bsel == C_RATE && !minute |-> !begin_c) else $error("rate pulse");
  rate_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bsel == C_RATE && rate_hit |-> begin_c) else $error("rate start");
  run_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && ev_nxt && !ev_r |=> run_cnt_r == RST_ZERO)
    else $error("run count");
  stop_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ssel == C_RATE && !ev_r |-> !stop_c) else $error("run stop idle");
  thr_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tsel == T_TIME |-> thq_c == time_gt_thr) else $error("time qualifier");
  // Regulator and tracker checks
  reg_band_a: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_dn |=> !reg_r) else $error("regulator band");
  reg_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_up |=> reg_r) else $error("regulator low");
  reg_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !reg_up && !reg_dn |=> $stable(reg_r)) else $error("regulator hold");
  trk_tgt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> mppt_target == $past(vtgt)) else $error("tracker target");
  trk_vbat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> mppt_vbat == $past(vbat)) else $error("tracker battery");
endmodule
